// ### xpt_pkg.sv
// constants and types shared by the crosspoint loader and its host controller
package xpt_pkg;
   // serial word layout
   localparam int WORD_BITS = 193;
   localparam int N_OUT = 32;
   localparam int N_IN = 32;
   localparam int SEL_W = 5;
   localparam int FIELD_W = 6;
   localparam int CLAMP_POS = 192;
   localparam int EN_POS = 5;
   localparam int SEL_POS = 0;
   // timing
   localparam int CLK_NS = 20;
   localparam int SCLK_PERIOD_NS = 160;
   localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / CLK_NS / 2;
   localparam int OVL_SWITCH_NS = 20;
   localparam int OVL_SWITCH_CYC = (OVL_SWITCH_NS / CLK_NS < 1) ? 1 : OVL_SWITCH_NS / CLK_NS;
   localparam int UPD_LOW_NS = 160;
   localparam int UPD_LOW_CYC = (UPD_LOW_NS + CLK_NS - 1) / CLK_NS;
   // host APB map
   localparam logic [7:0] DATA_BASE = 8'h00;
   localparam int N_DATA_REGS = 7;
   localparam logic [7:0] CTRL_OFS = 8'h1C;
   localparam logic [7:0] STATUS_OFS = 8'h20;
   localparam int CTRL_GO_BIT = 0;
   localparam int CTRL_RST_BIT = 1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_SDO_BIT = 2;
   // reset values
   localparam logic CTRL_RST_RESET = 1'b1;
   localparam logic [1:0] SYNC_HIGH_RESET = 2'h3;
   localparam logic [1:0] SYNC_LOW_RESET = 2'h0;
   localparam logic [2:0] SCLK_SYNC_RESET = 3'h0;
   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_LOW = 3'b001,
      H_HIGH = 3'b010,
      H_UPD = 3'b011
   } host_state_t;
endpackage

// ### xpt_link_if.sv
// serial programming link between host controller and crosspoint loader
`timescale 1ns/1ps
interface xpt_link_if;
   logic sclk;
   logic sdi;
   logic cs_n;
   logic update_n;
   logic reset_n;
   logic sdo;
   modport host (
      output sclk,
      output sdi,
      output cs_n,
      output update_n,
      output reset_n,
      input sdo
   );
   modport dev (
      input sclk,
      input sdi,
      input cs_n,
      input update_n,
      input reset_n,
      output sdo
   );
endinterface

// ### xpt_loader.sv
// device end: serial shift register, transfer latches and output decode
`timescale 1ns/1ps
module xpt_loader
   import xpt_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   xpt_link_if.dev link,
   input wire logic [N_OUT-1:0] overlay_select,
   output logic clamp_enable,
   output logic [N_OUT-1:0] out_enable,
   output logic [N_OUT-1:0][SEL_W-1:0] input_select_field,
   output logic [N_OUT-1:0][N_IN-1:0] stage_enable,
   output logic [N_OUT-1:0] overlay_path,
   output logic [7:0] bits_shifted,
   output logic word_complete
);

   typedef struct packed {
      logic [2:0] sclk_s;
      logic [1:0] sdi_s;
      logic [1:0] cs_s;
      logic [1:0] upd_s;
      logic [1:0] rst_s;
      logic [WORD_BITS-1:0] sr;
      logic [WORD_BITS-1:0] lat;
      logic [7:0] cnt;
      logic full;
      logic clamp;
      logic [N_OUT-1:0] oe;
      logic [N_OUT-1:0][SEL_W-1:0] sel;
      logic [N_OUT-1:0][N_IN-1:0] stage;
      logic [N_OUT-1:0] ovl;
   } dev_state_t;

   dev_state_t q;
   dev_state_t d;
   logic shift_edge;

   // one input stage per output, or none when the output is off
   function automatic logic [N_IN-1:0] stage_decode(input logic en, input logic [SEL_W-1:0] s);
      logic [N_IN-1:0] t;
      t = '0;
      t[s] = en;
      return t;
   endfunction

   // rising serial clock seen after the second synchroniser stage
   assign shift_edge = q.sclk_s[1] & ~q.sclk_s[2];

   // next state of all loader logic
   always_comb begin
      d = q;
      // pins cross in through two flops; sclk gets a third for edge finding
      d.sclk_s = {q.sclk_s[1:0], link.sclk};
      d.sdi_s = {q.sdi_s[0], link.sdi};
      d.cs_s = {q.cs_s[0], link.cs_n};
      d.upd_s = {q.upd_s[0], link.update_n};
      d.rst_s = {q.rst_s[0], link.reset_n};
      if (!q.rst_s[1]) begin
         d.sr = '0;
         d.lat = '0;
         d.cnt = '0;
         d.full = 1'b0;
      end else begin
         // select low gates the clock; with select high the word stays put
         if (!q.cs_s[1] && shift_edge) begin
            d.sr = {q.sr[WORD_BITS-2:0], q.sdi_s[1]};
            if (q.cnt == 8'(WORD_BITS - 1)) begin
               d.cnt = '0;
               d.full = 1'b1;
            end else begin
               d.cnt = q.cnt + 8'h01;
            end
         end
         // transparent rank: follows every shift while strobe is low
         if (!q.upd_s[1]) begin
            d.lat = q.sr;
         end
      end
      // first bit in ends at the top, so it is the global clamp
      d.clamp = q.rst_s[1] & q.lat[CLAMP_POS];
      for (int k = 0; k < N_OUT; k++) begin
         d.oe[k] = q.rst_s[1] & q.lat[k*FIELD_W+EN_POS];
         d.sel[k] = q.lat[k*FIELD_W+SEL_POS +: SEL_W];
         d.stage[k] = stage_decode(d.oe[k], d.sel[k]);
         // same-domain select; one register stage keeps the switch at one cycle
         d.ovl[k] = overlay_select[k];
      end
   end

   // the single state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.sclk_s <= SCLK_SYNC_RESET;
         q.cs_s <= SYNC_HIGH_RESET;
         q.upd_s <= SYNC_HIGH_RESET;
         q.rst_s <= SYNC_LOW_RESET;
      end else begin
         q <= d;
      end
   end

   // top bit leaves next; it entered 193 accepted edges ago
   assign link.sdo = q.sr[WORD_BITS-1];
   assign clamp_enable = q.clamp;
   assign out_enable = q.oe;
   assign input_select_field = q.sel;
   assign stage_enable = q.stage;
   assign overlay_path = q.ovl;
   assign bits_shifted = q.cnt;
   assign word_complete = q.full;

endmodule

// ### xpt_host.sv
// host end: APB-controlled serial programmer for the crosspoint loader
//
// How it works
// - one programming is exactly 193 bits
// - host pulls chip select low first
// - host keeps update strobe high while shifting
// - strobe low while shifting: latches follow shifts
// - data pin sampled on each serial clock rise
// - each output: enable bit plus 5-bit select
// - enable zero: output off, select ignored
// - first bit is clamp enable, 1 enables
// - host sends output 31 first, down to 0
// - per field: enable first, then select msb first
// - second rank transparent while strobe low
// - bits leaving shift register drive serial out
// - chain of N gets 193 times N bits
// - reset low forces all outputs disabled
// - host raises strobe before releasing reset
// - host strobes only after a full word
// - one clamp bit controls all inputs
// - overlay select high picks overlay, within 20 ns
// - overlay select driver times transitions to video
// - reset clears shift register and latches
// - decode enables one input stage or none
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module xpt_host
   import xpt_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   xpt_link_if.host link
);

   typedef struct packed {
      host_state_t st;
      logic [N_DATA_REGS*32-1:0] word;
      logic link_rst;
      logic link_rst_n;
      logic busy;
      logic done;
      logic [7:0] bitcnt;
      logic [2:0] tcnt;
      logic [1:0] sdo_s;
      logic sclk;
      logic sdi;
      logic cs_n;
      logic upd_n;
      logic [31:0] rdata;
      logic rdy;
      logic err;
   } host_reg_t;

   host_reg_t q;
   host_reg_t d;
   logic setup;
   logic wr;
   logic go;

   // apb phase decode
   assign setup = psel & ~penable;
   assign wr = psel & penable & pready & pwrite;
   assign go = wr && paddr == CTRL_OFS && pwdata[CTRL_GO_BIT] && q.st == H_IDLE;

   always_comb begin
      d = q;
      d.sdo_s = {q.sdo_s[0], link.sdo};
      // zero-wait slave: answer prepared in setup, ready in the access cycle
      d.rdy = setup;
      d.err = 1'b0;
      if (setup) begin
         d.rdata = '0;
         d.err = 1'b1;
         for (int i = 0; i < N_DATA_REGS; i++) begin
            if (paddr == DATA_BASE + 8'(i * 4)) begin
               d.rdata = q.word[i*32 +: 32];
               d.err = 1'b0;
            end
         end
         if (paddr == CTRL_OFS) begin
            d.rdata[CTRL_RST_BIT] = q.link_rst;
            d.err = 1'b0;
         end
         if (paddr == STATUS_OFS) begin
            d.rdata[STAT_BUSY_BIT] = q.busy;
            d.rdata[STAT_DONE_BIT] = q.done;
            d.rdata[STAT_SDO_BIT] = q.sdo_s[1];
            d.err = 1'b0;
         end
      end
      // data words are frozen while a word is going out
      if (wr && !q.busy) begin
         for (int i = 0; i < N_DATA_REGS; i++) begin
            if (paddr == DATA_BASE + 8'(i * 4)) begin
               d.word[i*32 +: 32] = (i == N_DATA_REGS - 1) ? {31'h0, pwdata[0]} : pwdata;
            end
         end
      end
      if (wr && paddr == CTRL_OFS) begin
         d.link_rst = pwdata[CTRL_RST_BIT];
      end
      // pin copy kept in its own flop so the link reset has no gate in front
      d.link_rst_n = ~d.link_rst;
      // serial sequencer
      case (q.st)
         H_IDLE: begin
            if (go) begin
               d.cs_n = 1'b0;
               d.sdi = q.word[CLAMP_POS];
               d.bitcnt = '0;
               d.tcnt = '0;
               d.busy = 1'b1;
               d.done = 1'b0;
               d.st = H_LOW;
            end
         end
         H_LOW: begin
            d.tcnt = q.tcnt + 3'h1;
            if (q.tcnt == 3'(SCLK_HALF_CYC - 1)) begin
               d.sclk = 1'b1;
               d.tcnt = '0;
               d.st = H_HIGH;
            end
         end
         H_HIGH: begin
            d.tcnt = q.tcnt + 3'h1;
            if (q.tcnt == 3'(SCLK_HALF_CYC - 1)) begin
               d.sclk = 1'b0;
               d.tcnt = '0;
               if (q.bitcnt == 8'(WORD_BITS - 1)) begin
                  d.cs_n = 1'b1;
                  d.upd_n = 1'b0;
                  d.st = H_UPD;
               end else begin
                  // output 31 field first, enable then select msb first
                  d.sdi = q.word[8'(CLAMP_POS - 1) - q.bitcnt];
                  d.bitcnt = q.bitcnt + 8'h01;
                  d.st = H_LOW;
               end
            end
         end
         H_UPD: begin
            d.tcnt = q.tcnt + 3'h1;
            if (q.tcnt == 3'(UPD_LOW_CYC - 1)) begin
               d.upd_n = 1'b1;
               d.busy = 1'b0;
               d.done = 1'b1;
               d.tcnt = '0;
               d.st = H_IDLE;
            end
         end
         default: begin
            d.st = H_IDLE;
         end
      endcase
   end

   // strobe high and link reset asserted from reset onward
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.st <= H_IDLE;
         q.link_rst <= CTRL_RST_RESET;
         q.link_rst_n <= ~CTRL_RST_RESET;
         q.cs_n <= 1'b1;
         q.upd_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign prdata = q.rdata;
   assign pready = q.rdy;
   assign pslverr = q.err;
   assign link.sclk = q.sclk;
   assign link.sdi = q.sdi;
   assign link.cs_n = q.cs_n;
   assign link.update_n = q.upd_n;
   assign link.reset_n = q.link_rst_n;

endmodule

// ### xpt_link_checker.sv
// assertions on the serial link between host and loader
`timescale 1ns/1ps
module xpt_link_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sclk,
   input wire logic sdi,
   input wire logic cs_n,
   input wire logic update_n,
   input wire logic reset_n
);
   logic sclk_q;
   logic [8:0] rise_q;
   // clock rises inside one select window; cleared while deselected
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_q <= 1'b0;
         rise_q <= 9'h000;
      end else begin
         sclk_q <= sclk;
         rise_q <= cs_n ? 9'h000 : rise_q + {8'h00, sclk & !sclk_q};
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_high4;
      sclk [*4] ##1 !sclk;
   endsequence
   sequence s_strobe8;
      !update_n [*8] ##1 update_n;
   endsequence
   a_frame_bit_count: assert property ($rose(cs_n) |-> rise_q == 9'h0C1)
      else $error("frame length wrong");
   a_select_before_clk: assert property ($rose(sclk) |-> !cs_n)
      else $error("clock without select");
   a_strobe_idle_shift: assert property (!cs_n |-> update_n)
      else $error("strobe low while shifting");
   a_sdi_on_fall: assert property (!cs_n && !$past(cs_n) && $changed(sdi) |-> $fell(sclk))
      else $error("data moved off the falling clock");
   a_clock_high_len: assert property ($rose(sclk) |-> s_high4)
      else $error("clock high time wrong");
   a_strobe_pulse_len: assert property ($fell(update_n) |-> s_strobe8)
      else $error("strobe pulse length wrong");
   a_word_then_strobe: assert property ($fell(update_n) |->
      $rose(cs_n) && rise_q == 9'h0C1) else $error("strobe before a full word");
   a_strobe_before_rel: assert property ($rose(reset_n) |-> update_n && $past(update_n))
      else $error("reset released with strobe low");
endmodule

// ### crosspoint_serial_config_loader_bench.sv
// self-checking bench: host and loader joined over the serial link
`timescale 1ns/1ps
module crosspoint_serial_config_loader_bench;
   import xpt_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
   logic [7:0] paddr, bs, bs_b;
   logic [31:0] pwdata, prdata, rd;
   logic [N_OUT-1:0] ovl, ovl_path, oen;
   logic [N_OUT-1:0][SEL_W-1:0] isel;
   logic [N_OUT-1:0][N_IN-1:0] stg;
   logic clamp, clamp_b, wc_b;
   logic [223:0] w;
   logic sq[$];
   int err_total, cmp_count, n;
   xpt_link_if lk();
   xpt_link_if lk2();
   xpt_host xpt_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(lk.host));
   xpt_loader xpt_loader_inst (.pclk(pclk), .presetn(presetn), .link(lk.dev),
      .overlay_select(ovl), .clamp_enable(clamp), .out_enable(oen), .input_select_field(isel),
      .stage_enable(stg), .overlay_path(ovl_path), .bits_shifted(bs), .word_complete());
   // second loader on a bench-driven link, for misuse and chaining
   xpt_loader xpt_loader_inst_b (.pclk(pclk), .presetn(presetn), .link(lk2.dev),
      .overlay_select(ovl), .clamp_enable(clamp_b), .out_enable(), .input_select_field(),
      .stage_enable(), .overlay_path(), .bits_shifted(bs_b), .word_complete(wc_b));
   xpt_link_checker xpt_link_checker_inst (.pclk(pclk), .presetn(presetn), .sclk(lk.sclk),
      .sdi(lk.sdi), .cs_n(lk.cs_n), .update_n(lk.update_n), .reset_n(lk.reset_n));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // one apb transfer; waits for pready, bounded
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'h2, wr, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         err_total++;
         finish_test();
      end
   endtask
   // one serial bit on the bench link: 4 cycles low, 4 high; queue models the 193-stage delay
   task automatic sh(input logic b, input int j);
      logic e;
      lk2.sdi <= b;
      lk2.sclk <= 1'b0;
      repeat (4) @(posedge pclk);
      if (sq.size() == WORD_BITS) begin
         e = sq.pop_front();
         chk(lk2.sdo, e);
         if (j >= 300) chk(clamp_b, e);
      end
      // deselected bits (j below 0) never enter the model
      if (j >= 0) sq.push_back(b);
      lk2.sclk <= 1'b1;
      repeat (4) @(posedge pclk);
   endtask
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, ovl} <= '0;
      {lk2.sclk, lk2.sdi, lk2.reset_n, lk2.cs_n, lk2.update_n} <= 5'h03;
      void'($urandom(32'h9CDF6700));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      lk2.reset_n <= 1'b1;
      apb(1'b0, CTRL_OFS, 32'h0);
      chk(rd, 32'h2);
      apb(1'b0, 8'h40, 32'h0);
      chk(serr, 1'b1);
      chk(rd, 32'h0);
      apb(1'b1, CTRL_OFS, 32'h0);
      // random words through the host, then compare decoded outputs
      for (int r = 0; r < 3; r++) begin
         for (int i = 0; i < N_DATA_REGS; i++) begin
            w[i*32 +: 32] = $urandom & ((i == 6) ? 32'h1 : 32'hFFFFFFFF);
            // last word keeps the clamp set so the link reset has something to clear
            if (r == 2) w[CLAMP_POS] = 1'b1;
            apb(1'b1, DATA_BASE + 8'(i*4), w[i*32 +: 32]);
         end
         apb(1'b0, DATA_BASE + 8'h18, 32'h0);
         chk(rd, {31'h0, w[CLAMP_POS]});
         apb(1'b1, CTRL_OFS, 32'h1);
         // data write while busy must be ignored, or the last fields go out wrong
         apb(1'b1, DATA_BASE, ~w[31:0]);
         rd = 32'h0;
         for (int p = 0; p < 1000 && rd[STAT_DONE_BIT] !== 1'b1; p++) begin
            apb(1'b0, STATUS_OFS, 32'h0);
         end
         if (rd[STAT_DONE_BIT] !== 1'b1) begin
            err_total++;
            finish_test();
         end
         chk(rd[2:0], {w[CLAMP_POS], 2'b10});
         ovl <= N_OUT'($urandom);
         repeat (2) @(posedge pclk);
         #1;
         chk(ovl_path, ovl);
         chk(clamp, w[CLAMP_POS]);
         for (int k = 0; k < N_OUT; k++) begin
            chk(oen[k], w[k*FIELD_W+EN_POS]);
            chk(isel[k], w[k*FIELD_W+SEL_POS +: SEL_W]);
            chk(stg[k], w[k*FIELD_W+EN_POS] ? 32'h1 << w[k*FIELD_W +: SEL_W] : 32'h0);
         end
      end
      // link reset drops every output and the shift count
      apb(1'b1, CTRL_OFS, 32'h2);
      repeat (8) @(posedge pclk);
      #1;
      chk(clamp, 1'b0);
      chk(oen, 32'h0);
      chk(bs, 8'h00);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(rd[STAT_SDO_BIT], 1'b0);
      apb(1'b1, CTRL_OFS, 32'h0);
      // deselected clocks ignored, then two words pass through, strobe low late
      @(posedge pclk);
      for (int j = 0; j < 5; j++) sh(1'b1, -1);
      chk(bs_b, 8'h00);
      lk2.cs_n <= 1'b0;
      for (int j = 0; j < 386; j++) begin
         if (j == 296) lk2.update_n <= 1'b0;
         sh(1'($urandom), j);
      end
      chk({wc_b, bs_b}, 9'h100);
      finish_test();
   end
endmodule
